// *** rtl/press_regs_pkg.sv ***
// Purpose: Shared constants for the pressure sensor result/status bank
// Assumes: Byte-wide registers reached through a byte read port
// Notes:   Offsets, field positions and widths live only here
//
// Functional notes
// R1 - Watermark flag bit 7 set while count reaches the level; with a zero level the code never sets it.
// R2 - Overrun flag bit 6 when full and a sample overwritten.
// R3 - Full flag bit 5 when filled with nothing overwritten.
// R4 - Status bit 5 when a new temperature replaces an unread one.
// R5 - Status bit 4 when a new pressure replaces an unread one.
// R6 - Status bit 1 once a new temperature is produced.
// R7 - Status bit 0 once a new pressure is produced.
// R8 - Status refreshed every conversion cycle.
// R9 - Pressure: 24-bit two's complement, low byte first.
// R10 - Functions off: pressure is measured minus offset.
// R11 - Temperature is 16-bit two's complement, low byte first.
// R12 - Queue head pressure as three bytes, low first.
// R13 - Queue head temperature as two bytes, low first.
// R14 - Host reads queue bytes singly or as a burst.
// R15 - Offset: 16-bit two's complement from two bytes.
// R16 - Limit enabled: queue full at watermark count; with a zero level the code keeps the full depth.
// R17 - Last queue temperature byte read advances the head.
// R18 - Multi-byte reads return one coherent sample.

package press_regs_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_FIFO_FILL_FLAGS   = 8'h26;
    localparam logic [7:0] ADDR_SAMPLE_STATUS     = 8'h27;
    localparam logic [7:0] ADDR_PRESS_RESULT_LOW  = 8'h28;
    localparam logic [7:0] ADDR_PRESS_RESULT_MID  = 8'h29;
    localparam logic [7:0] ADDR_PRESS_RESULT_HIGH = 8'h2A;
    localparam logic [7:0] ADDR_TEMP_RESULT_LOW   = 8'h2B;
    localparam logic [7:0] ADDR_TEMP_RESULT_HIGH  = 8'h2C;
    localparam logic [7:0] ADDR_QUEUED_PRESS_LOW  = 8'h78;
    localparam logic [7:0] ADDR_QUEUED_PRESS_MID  = 8'h79;
    localparam logic [7:0] ADDR_QUEUED_PRESS_HIGH = 8'h7A;
    localparam logic [7:0] ADDR_QUEUED_TEMP_LOW   = 8'h7B;
    localparam logic [7:0] ADDR_QUEUED_TEMP_HIGH  = 8'h7C;

    // Field positions
    localparam int BIT_QUEUE_WATERMARK = 7;
    localparam int BIT_QUEUE_OVERRUN   = 6;
    localparam int BIT_QUEUE_FULL      = 5;
    localparam int BIT_TEMP_OVERRUN    = 5;
    localparam int BIT_PRESS_OVERRUN   = 4;
    localparam int BIT_TEMP_AVAILABLE  = 1;
    localparam int BIT_PRESS_AVAILABLE = 0;

    // Widths and defaults
    localparam int PRESS_W        = 24;
    localparam int TEMP_W         = 16;
    localparam int OFFSET_W       = 16;
    localparam int WTM_W          = 5;
    localparam int QUEUE_DEPTH    = 32;
    localparam int ENTRY_W        = PRESS_W + TEMP_W;

    // Byte indices inside a multi-byte result
    localparam logic [1:0] BYTE_LOW  = 2'h0;
    localparam logic [1:0] BYTE_MID  = 2'h1;
    localparam logic [1:0] BYTE_HIGH = 2'h2;

    localparam logic [7:0] READ_ZERO = 8'h00;

    // Picks one byte out of a 24-bit word
    function automatic logic [7:0] byte_of(input logic [23:0] word,
                                           input logic [1:0]  idx);
        logic [7:0] sel;
        sel = 8'h00;
        case (idx)
            BYTE_LOW:  sel = word[7:0];
            BYTE_MID:  sel = word[15:8];
            BYTE_HIGH: sel = word[23:16];
            default:   sel = 8'h00;
        endcase
        return sel;
    endfunction : byte_of

endpackage : press_regs_pkg

// *** rtl/pressure_adjust.sv ***
// Purpose: Registers the pressure result after offset correction
// Assumes: Raw pressure and offset are valid with i_load
// Notes:   One cycle of latency from i_load to o_valid

`timescale 1ns/1ps

module pressure_adjust
    import press_regs_pkg::*;
(
    input  wire logic                i_core_clk,
    input  wire logic                i_sys_rst,
    input  wire logic                i_load,
    input  wire logic [PRESS_W-1:0]  i_raw,
    input  wire logic [OFFSET_W-1:0] i_offset,
    input  wire logic                i_bypass,
    output logic      [PRESS_W-1:0]  o_result,
    output logic                     o_valid
);

    logic [PRESS_W-1:0] offset_ext;
    logic [PRESS_W-1:0] nxt_result;
    logic [PRESS_W-1:0] result_ff;
    logic               valid_ff;

    // Sign extension keeps negative offsets correct
    assign offset_ext = {{(PRESS_W-OFFSET_W){i_offset[OFFSET_W-1]}},
                         i_offset};                              // R15
    // Reference functions do their own arithmetic elsewhere
    assign nxt_result = i_bypass ? i_raw : (i_raw - offset_ext);  // R10

    // Result and its strobe
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            result_ff <= '0;
            valid_ff  <= 1'b0;
        end
        else
        begin
            valid_ff <= i_load;
            if (i_load)
            begin
                result_ff <= nxt_result;
            end
        end
    end

    assign o_result = result_ff;
    assign o_valid  = valid_ff;

endmodule : pressure_adjust

// *** rtl/sample_queue.sv ***
// Purpose: Sample queue that overwrites its oldest entry when full
// Assumes: Capacity limit never exceeds DEPTH
// Notes:   Pop on an empty queue is ignored

`timescale 1ns/1ps

module sample_queue
    import press_regs_pkg::*;
#(
    parameter int W     = ENTRY_W,
    parameter int DEPTH = QUEUE_DEPTH,
    parameter int CW    = $clog2(DEPTH + 1),
    parameter int PW    = $clog2(DEPTH)
)
(
    input  wire logic          i_core_clk,
    input  wire logic          i_sys_rst,
    input  wire logic          i_push,
    input  wire logic [W-1:0]  i_data,
    input  wire logic          i_pop,
    input  wire logic [CW-1:0] i_cap,
    output logic      [W-1:0]  o_head,
    output logic      [CW-1:0] o_count,
    output logic               o_full,
    output logic               o_overrun
);

    localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);
    localparam logic [CW-1:0] ONE      = CW'(1);

    logic [W-1:0]  store_ff [DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [CW-1:0] count_ff;
    logic          ovr_ff;
    logic          do_pop;
    logic          full_now;
    logic          overwrite;

    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        return (p == LAST_IDX) ? '0 : p + PW'(1);
    endfunction : step

    assign do_pop    = i_pop && (count_ff != '0);
    assign full_now  = (count_ff >= i_cap);
    assign overwrite = i_push && full_now && !do_pop;

    // Storage write
    always_ff @(posedge i_core_clk)
    begin
        if (i_push)
        begin
            store_ff[wr_ff] <= i_data;
        end
    end

    // Pointers and fill count; overwrite drops the oldest entry
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            wr_ff    <= '0;
            rd_ff    <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (i_push)
            begin
                wr_ff <= step(wr_ff);
            end
            if (do_pop || overwrite)
            begin
                rd_ff <= step(rd_ff);
            end
            if (i_push && !do_pop && !overwrite)
            begin
                count_ff <= count_ff + ONE;
            end
            else if (!i_push && do_pop)
            begin
                count_ff <= count_ff - ONE;
            end
        end
    end

    // Overrun sticks until a pop; a new overwrite wins
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            ovr_ff <= 1'b0;
        end
        else if (overwrite)
        begin
            ovr_ff <= 1'b1;                                       // R2
        end
        else if (do_pop)
        begin
            ovr_ff <= 1'b0;
        end
    end

    assign o_head    = (count_ff == '0) ? '0 : store_ff[rd_ff];
    assign o_count   = count_ff;
    assign o_full    = full_now;
    assign o_overrun = ovr_ff;

endmodule : sample_queue

// *** rtl/pressure_status_regs.sv ***
// Purpose: Result, status and queue head byte registers of the sensor
// Assumes: Conversion logic and serial register engine share i_core_clk
// Notes:   Reads answer one cycle after the request, from flip-flops

`timescale 1ns/1ps

module pressure_status_regs
    import press_regs_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH
)
(
    input  wire logic                i_core_clk,
    input  wire logic                i_sys_rst,
    input  wire logic                i_conv_done,
    input  wire logic [PRESS_W-1:0]  i_press_raw,
    input  wire logic [TEMP_W-1:0]   i_temp_raw,
    input  wire logic [OFFSET_W-1:0] i_pressure_offset,
    input  wire logic                i_differential_enable,
    input  wire logic                i_auto_zero_function,
    input  wire logic                i_auto_reference_function,
    input  wire logic [WTM_W-1:0]    i_watermark_level,
    input  wire logic                i_watermark_limit_enable,
    input  wire logic                i_xfer_active,
    input  wire logic                i_rd_en,
    input  wire logic [7:0]          i_rd_addr,
    output logic      [7:0]          o_rd_data,
    output logic                     o_rd_valid
);

    localparam int CW = $clog2(DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////

    logic [PRESS_W-1:0] adj_press;
    logic               adj_valid;
    logic               bypass;
    logic [TEMP_W-1:0]  temp_pend_ff;

    logic [PRESS_W-1:0] press_res_ff;
    logic [TEMP_W-1:0]  temp_res_ff;
    logic [PRESS_W-1:0] press_snap_ff;
    logic [TEMP_W-1:0]  temp_snap_ff;

    logic               press_avail_ff;
    logic               temp_avail_ff;
    logic               press_ovr_ff;
    logic               temp_ovr_ff;

    logic [ENTRY_W-1:0] head;
    logic [ENTRY_W-1:0] head_snap_ff;
    logic [CW-1:0]      q_count;
    logic               q_full;
    logic               q_overrun;
    logic [CW-1:0]      q_cap;
    logic [CW-1:0]      wtm_ext;
    logic               q_pop;

    logic               rd_press_high;
    logic               rd_temp_high;
    logic [7:0]         fill_flags;
    logic [7:0]         status_byte;
    logic [7:0]         nxt_rd_data;
    logic [7:0]         rd_data_ff;
    logic               rd_valid_ff;

    ////////////////////////////////////////////////////////////////////////
    // Conversion path
    ////////////////////////////////////////////////////////////////////////

    // Offset only applies with every reference function off
    assign bypass = i_differential_enable || i_auto_zero_function ||
                    i_auto_reference_function;                    // R10

    pressure_adjust u_adjust
    (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_load     (i_conv_done),
        .i_raw      (i_press_raw),
        .i_offset   (i_pressure_offset),
        .i_bypass   (bypass),
        .o_result   (adj_press),
        .o_valid    (adj_valid)
    );

    // Temperature delayed to stay aligned with the adjusted pressure
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            temp_pend_ff <= '0;
        end
        else if (i_conv_done)
        begin
            temp_pend_ff <= i_temp_raw;
        end
    end

    // Live result words
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            press_res_ff <= '0;
            temp_res_ff  <= '0;
        end
        else if (adj_valid)
        begin
            press_res_ff <= adj_press;                            // R9
            temp_res_ff  <= temp_pend_ff;                         // R11
        end
    end

    // Frozen while the host is in a transaction, so a burst
    // never mixes two conversions
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            press_snap_ff <= '0;
            temp_snap_ff  <= '0;
            head_snap_ff  <= '0;
        end
        else if (!i_xfer_active)
        begin
            press_snap_ff <= press_res_ff;                        // R18
            temp_snap_ff  <= temp_res_ff;                         // R18
            head_snap_ff  <= head;                                // R18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data status flags
    ////////////////////////////////////////////////////////////////////////

    assign rd_press_high = i_rd_en && (i_rd_addr == ADDR_PRESS_RESULT_HIGH);
    assign rd_temp_high  = i_rd_en && (i_rd_addr == ADDR_TEMP_RESULT_HIGH);

    // Pressure flags; a new result beats a clearing read
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            press_avail_ff <= 1'b0;
            press_ovr_ff   <= 1'b0;
        end
        else if (adj_valid)
        begin
            press_ovr_ff   <= press_avail_ff;                     // R5 R8
            press_avail_ff <= 1'b1;                               // R7 R8
        end
        else if (rd_press_high)
        begin
            press_ovr_ff   <= 1'b0;
            press_avail_ff <= 1'b0;                               // R7
        end
    end

    // Temperature flags; same priority as pressure
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            temp_avail_ff <= 1'b0;
            temp_ovr_ff   <= 1'b0;
        end
        else if (adj_valid)
        begin
            temp_ovr_ff   <= temp_avail_ff;                       // R4 R8
            temp_avail_ff <= 1'b1;                                // R6 R8
        end
        else if (rd_temp_high)
        begin
            temp_ovr_ff   <= 1'b0;
            temp_avail_ff <= 1'b0;                                // R6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample queue
    ////////////////////////////////////////////////////////////////////////

    assign wtm_ext = CW'(i_watermark_level);

    // Zero watermark would leave no room, so keep full depth
    assign q_cap = (i_watermark_limit_enable && (wtm_ext != '0)) ?
                   wtm_ext : CW'(DEPTH);                          // R16

    // Temperature high byte read pops the head,
    // whether alone or ending a burst
    assign q_pop = i_rd_en && (i_rd_addr == ADDR_QUEUED_TEMP_HIGH); // R17 R14

    sample_queue #(
        .W     (ENTRY_W),
        .DEPTH (DEPTH)
    ) u_queue
    (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_push     (adj_valid),
        .i_data     ({temp_pend_ff, adj_press}),
        .i_pop      (q_pop),
        .i_cap      (q_cap),
        .o_head     (head),
        .o_count    (q_count),
        .o_full     (q_full),
        .o_overrun  (q_overrun)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status byte assembly
    ////////////////////////////////////////////////////////////////////////

    // Full and overrun are exclusive as seen by the host
    always_comb
    begin
        fill_flags = 8'h00;
        fill_flags[BIT_QUEUE_WATERMARK] =
            (wtm_ext != '0) && (q_count >= wtm_ext);              // R1
        fill_flags[BIT_QUEUE_OVERRUN] = q_full && q_overrun;      // R2
        fill_flags[BIT_QUEUE_FULL]    = q_full && !q_overrun;     // R3
    end

    // Unused status bits read as zero
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[BIT_TEMP_OVERRUN]    = temp_ovr_ff;           // R4
        status_byte[BIT_PRESS_OVERRUN]   = press_ovr_ff;          // R5
        status_byte[BIT_TEMP_AVAILABLE]  = temp_avail_ff;         // R6
        status_byte[BIT_PRESS_AVAILABLE] = press_avail_ff;        // R7
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port
    ////////////////////////////////////////////////////////////////////////

    // Address decode; unmapped addresses return zero
    always_comb
    begin
        nxt_rd_data = READ_ZERO;
        case (i_rd_addr)
            ADDR_FIFO_FILL_FLAGS:   nxt_rd_data = fill_flags;
            ADDR_SAMPLE_STATUS:     nxt_rd_data = status_byte;
            ADDR_PRESS_RESULT_LOW:
                nxt_rd_data = byte_of(press_snap_ff, BYTE_LOW);   // R9
            ADDR_PRESS_RESULT_MID:
                nxt_rd_data = byte_of(press_snap_ff, BYTE_MID);   // R9
            ADDR_PRESS_RESULT_HIGH:
                nxt_rd_data = byte_of(press_snap_ff, BYTE_HIGH);  // R9
            ADDR_TEMP_RESULT_LOW:
                nxt_rd_data = byte_of({8'h00, temp_snap_ff},
                                      BYTE_LOW);                  // R11
            ADDR_TEMP_RESULT_HIGH:
                nxt_rd_data = byte_of({8'h00, temp_snap_ff},
                                      BYTE_MID);                  // R11
            ADDR_QUEUED_PRESS_LOW:
                nxt_rd_data = byte_of(head_snap_ff[PRESS_W-1:0],
                                      BYTE_LOW);                  // R12
            ADDR_QUEUED_PRESS_MID:
                nxt_rd_data = byte_of(head_snap_ff[PRESS_W-1:0],
                                      BYTE_MID);                  // R12
            ADDR_QUEUED_PRESS_HIGH:
                nxt_rd_data = byte_of(head_snap_ff[PRESS_W-1:0],
                                      BYTE_HIGH);                 // R12
            ADDR_QUEUED_TEMP_LOW:
                nxt_rd_data = byte_of({8'h00,
                                       head_snap_ff[ENTRY_W-1:PRESS_W]},
                                      BYTE_LOW);                  // R13
            ADDR_QUEUED_TEMP_HIGH:
                nxt_rd_data = byte_of({8'h00,
                                       head_snap_ff[ENTRY_W-1:PRESS_W]},
                                      BYTE_MID);                  // R13
            default:                nxt_rd_data = READ_ZERO;
        endcase
    end

    // Registered answer, one cycle after the request
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            rd_data_ff  <= READ_ZERO;
            rd_valid_ff <= 1'b0;
        end
        else
        begin
            rd_valid_ff <= i_rd_en;
            if (i_rd_en)
            begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    assign o_rd_data  = rd_data_ff;
    assign o_rd_valid = rd_valid_ff;

endmodule : pressure_status_regs

// *** verification/pressure_status_regs_chk.sv ***
// Purpose: Port level checks on the result and status byte bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound onto every instance of the bank
`timescale 1ns/1ps
module pressure_status_regs_chk
    import press_regs_pkg::*;
(
    input wire logic       i_core_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_conv_done,
    input wire logic       i_xfer_active,
    input wire logic       i_rd_en,
    input wire logic [7:0] i_rd_addr,
    input wire logic [7:0] o_rd_data,
    input wire logic       o_rd_valid
);
////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    // Request decodes
    wire st_rd  = i_rd_en && i_rd_addr == ADDR_SAMPLE_STATUS;
    wire ff_rd  = i_rd_en && i_rd_addr == ADDR_FIFO_FILL_FLAGS;
    wire clr_rd = i_rd_en && (i_rd_addr == ADDR_PRESS_RESULT_HIGH
                  || i_rd_addr == ADDR_TEMP_RESULT_HIGH);
////////////////////////////////////////////////////////////
    a_answer_one_cycle: assert property (i_rd_en |=> o_rd_valid)
        else $error("read request not answered next cycle");
    a_no_spurious_valid: assert property (!i_rd_en |=> !o_rd_valid)
        else $error("read answer without request");
    a_reset_quiet: assert property ($fell(i_sys_rst) |->
        !o_rd_valid && o_rd_data == 8'h00) else $error("reset not clean");
    a_fill_reserved: assert property (ff_rd |=>
        o_rd_data[4:0] == 5'h00) else $error("fill flags low bits set");
    a_flags_exclusive: assert property (ff_rd |=>
        !(o_rd_data[6] && o_rd_data[5])) else $error("full and overrun");
    a_status_reserved: assert property (st_rd |=>
        (o_rd_data & 8'hCC) == 8'h00) else $error("status spare bits set");
    a_overrun_has_avail: assert property (st_rd |=>
        (!o_rd_data[4] || o_rd_data[0]) && (!o_rd_data[5] || o_rd_data[1]))
        else $error("overrun without available");
    a_avail_after_conv: assert property (i_conv_done ##1
        (!clr_rd throughout (1'b1 ##[1:9] st_rd)) |=> o_rd_data[1:0] == 2'h3)
        else $error("available bits missing after conversion");
    // Main scenarios
    c_full: cover property (ff_rd ##1 o_rd_data[5]);
    c_overrun: cover property (st_rd ##1 o_rd_data[4]);
    c_burst: cover property (i_xfer_active && i_rd_en ##1 i_rd_en);
endmodule : pressure_status_regs_chk

bind pressure_status_regs pressure_status_regs_chk u_chk (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_conv_done(i_conv_done), .i_xfer_active(i_xfer_active),
    .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid)
);

// *** verification/host_reader.sv ***
// Purpose: Host side of the byte read port, single and burst reads
// Assumes: Requests change on the falling edge, answer one cycle later
// Notes:   Captured bytes stay in got for the bench to judge
`timescale 1ns/1ps
module host_reader
(
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_valid,
    output logic            o_xfer_active,
    output logic            o_rd_en,
    output logic [7:0]      o_rd_addr
);
    logic [7:0] got [0:6];
    // Idle bus at time zero
    initial
    begin
        o_xfer_active = 1'b0;
        o_rd_en = 1'b0;
        o_rd_addr = 8'h00;
    end
    // Released address inverted so a stale value never matches
    task automatic rd(input logic [7:0] a, input int n);
        @(negedge i_core_clk);
        o_xfer_active = 1'b1;
        for (int k = 0; k <= n; k++)
        begin
            @(negedge i_core_clk);
            if (k > 0)
                got[k-1] = i_rd_valid ? i_rd_data : 8'hXX;
            o_rd_en = (k < n);
            o_rd_addr = (k < n) ? a + 8'(k) : ~o_rd_addr;
        end
        @(negedge i_core_clk);
        o_xfer_active = 1'b0;
    endtask : rd
endmodule : host_reader

// *** verification/pressure_status_regs_tb.sv ***
// Purpose: Self-checking bench for the result and status byte bank
// Assumes: Inputs change on the falling edge of the clock
// Notes:   Queue capacity checked through the watermark limit
`timescale 1ns/1ps
module pressure_status_regs_tb
    import press_regs_pkg::*;
;
    logic                clk, rst, conv, dif_en, az_en, ar_en;
    logic [PRESS_W-1:0]  praw;
    logic [TEMP_W-1:0]   traw;
    logic [OFFSET_W-1:0] offs;
    logic [WTM_W-1:0]    watermark_level;
    logic                wtm_lim, xfer, rd_en, rd_valid;
    logic [7:0]          rd_addr, rd_data;
    int                  err_count, comparisons, cycles;
////////////////////////////////////////////////////////////
    pressure_status_regs dut (
        .i_core_clk(clk), .i_sys_rst(rst), .i_conv_done(conv),
        .i_press_raw(praw), .i_temp_raw(traw), .i_pressure_offset(offs),
        .i_differential_enable(dif_en), .i_auto_zero_function(az_en),
        .i_auto_reference_function(ar_en), .i_watermark_level(watermark_level),
        .i_watermark_limit_enable(wtm_lim), .i_xfer_active(xfer),
        .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid));
    host_reader host (
        .i_core_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
        .o_xfer_active(xfer), .o_rd_en(rd_en), .o_rd_addr(rd_addr));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Ceiling well above the run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            finish_test();
        end
    end
////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Captured bytes from index at, low byte first
    task automatic chk_bytes(input string nm, input int at,
                             input logic [55:0] v, input int n);
        for (int k = 0; k < n; k++)
            chk(nm, v[8*k +: 8], host.got[at+k]);
    endtask : chk_bytes
    task automatic conv_step(input logic [23:0] p, input logic [15:0] t);
        @(negedge clk);
        conv = 1'b1;
        praw = p;
        traw = t;
        @(negedge clk);
        conv = 1'b0;
        repeat (4) @(negedge clk);
    endtask : conv_step
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
////////////////////////////////////////////////////////////
    task automatic t_reset();
        host.rd(ADDR_FIFO_FILL_FLAGS, 7);
        chk_bytes("bank after reset", 0, 56'h0, 7);
        host.rd(ADDR_QUEUED_PRESS_LOW, 5);
        chk_bytes("empty queue head", 0, 56'h0, 5);
        $display("test reset done");
    endtask : t_reset
    // Negative offset: raw 123456h minus -16 gives 123466h
    task automatic t_results();
        offs = 16'hFFF0;
        conv_step(24'h123456, 16'h8123);
        host.rd(ADDR_SAMPLE_STATUS, 6);
        chk("status new", 8'h03, host.got[0]);
        chk_bytes("pressure", 1, 56'h123466, 3);
        chk_bytes("temperature", 4, 56'h8123, 2);
        host.rd(ADDR_SAMPLE_STATUS, 1);
        chk("status cleared", 8'h00, host.got[0]);
        $display("test results done");
    endtask : t_results
    // Second result lands before the first is read
    task automatic t_overrun();
        az_en = 1'b1;
        conv_step(24'hFEDCBA, 16'h1234);
        az_en = 1'b0;
        dif_en = 1'b1;
        conv_step(24'h00ABCD, 16'h0042);
        dif_en = 1'b0;
        host.rd(ADDR_SAMPLE_STATUS, 6);
        chk("status twice", 8'h33, host.got[0]);
        chk_bytes("raw result", 1, 56'h004200ABCD, 5);
        $display("test overrun done");
    endtask : t_overrun
    // Three samples queued against a level of three
    task automatic t_queue();
        host.rd(ADDR_FIFO_FILL_FLAGS, 1);
        chk("fill at level", 8'h80, host.got[0]);
        host.rd(ADDR_QUEUED_PRESS_LOW, 5);
        chk_bytes("head first", 0, 56'h8123123466, 5);
        host.rd(ADDR_FIFO_FILL_FLAGS, 1);
        chk("fill below", 8'h00, host.got[0]);
        host.rd(ADDR_QUEUED_PRESS_LOW, 5);
        chk_bytes("head next", 0, 56'h1234FEDCBA, 5);
        $display("test queue done");
    endtask : t_queue
    // Limit of four; positive offset drives pressure negative
    task automatic t_full();
        watermark_level = 5'h04;
        wtm_lim = 1'b1;
        offs = 16'h0100;
        for (int k = 0; k < 3; k++)
            conv_step(24'h000010 + 24'(k), 16'h0700);
        host.rd(ADDR_FIFO_FILL_FLAGS, 1);
        chk("fill full", 8'hA0, host.got[0]);
        ar_en = 1'b1;
        conv_step(24'h000020, 16'h0700);
        ar_en = 1'b0;
        host.rd(ADDR_FIFO_FILL_FLAGS, 1);
        chk("fill overrun", 8'hC0, host.got[0]);
        host.rd(ADDR_PRESS_RESULT_LOW, 3);
        chk_bytes("reference raw", 0, 56'h20, 3);
        host.rd(ADDR_QUEUED_PRESS_LOW, 5);
        chk_bytes("head after loss", 0, 56'h0700FFFF10, 5);
        host.rd(ADDR_FIFO_FILL_FLAGS, 1);
        chk("fill after pop", 8'h00, host.got[0]);
        $display("test full done");
    endtask : t_full
////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        conv = 1'b0;
        praw = 24'h000000;
        traw = 16'h0000;
        offs = 16'h0000;
        dif_en = 1'b0;
        az_en = 1'b0;
        ar_en = 1'b0;
        watermark_level = 5'h03;
        wtm_lim = 1'b0;
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_results();
        t_overrun();
        t_queue();
        t_full();
        finish_test();
    end
endmodule : pressure_status_regs_tb
